// ---- hw/oslr_map.svh ----
// Purpose: Offsets, field positions, reset values and counts for the limits register bank
// Assumes: Registers reached as byte locations by the control interface
// Notes: Reset values are plain defaults
`ifndef OSLR_MAP_SVH
`define OSLR_MAP_SVH

`define OSLR_ADDR_MODULE 8'h15
`define OSLR_ADDR_LIMCFG 8'h16

`define OSLR_MOD_LSB 4
`define OSLR_MOD_MSB 7
`define OSLR_THERMAL_ENABLE_A_BIT 0
`define OSLR_RSTFLAG_BIT 1
`define OSLR_FORCE_BIT 2
`define OSLR_TPW_LSB 4
`define OSLR_TPW_MSB 5
`define OSLR_IPK_LSB 6
`define OSLR_IPK_MSB 7

`define OSLR_MOD_RST 4'h7
`define OSLR_THERMAL_ENABLE_A_RST 1'h0
`define OSLR_TPW_RST 2'h0
`define OSLR_IPK_RST 2'h3

`define OSLR_MOD_MAX 4'h7
`define OSLR_PWRUP_CYCLES 8'h10

`endif

// ---- hw/oslr_pkg.sv ----
// Purpose: Types for the limits register bank
// Assumes: Used with oslr_map.svh
// Notes: None
package oslr_pkg;
  typedef enum logic [1:0] {TS_RUN, TS_OFF, TS_PWRUP} oslr_ts_state_t;
  typedef enum logic [1:0] {IPK_2P9A, IPK_3P4A, IPK_3P9A} oslr_ipk_sel_t;
  typedef enum logic [1:0] {TPW_83C, TPW_94C, TPW_105C, TPW_116C} oslr_tpw_sel_t;
endpackage

// ---- hw/oslr_decode.sv ----
// Purpose: Decodes stored fields into analog trim selections
// Assumes: Fields come from registers on the same clock
// Notes: Outputs registered
`timescale 1ns/1ps
`include "oslr_map.svh"

module oslr_decode (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fields
  input wire logic [3:0] module_count_field_i,
  input wire logic [1:0] thermal_prewarn_threshold_i,
  input wire logic [1:0] inductor_peak_limit_i,
  // Decoded
  output logic [7:0] module_enable_o,
  output oslr_pkg::oslr_tpw_sel_t tpw_sel_o,
  output oslr_pkg::oslr_ipk_sel_t ipk_sel_o
);
  logic [3:0] active_cnt;

  // Codes of seven and above saturate to eight modules
  always_comb
  begin
    if (module_count_field_i >= `OSLR_MOD_MAX)
      active_cnt = 4'h8;
    else
      active_cnt = module_count_field_i + 4'h1;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_mod
      always_ff @(posedge clk_i or posedge rst_i)
      begin
        if (rst_i)
          module_enable_o[gi] <= 1'b0;
        else
          module_enable_o[gi] <= (4'(gi) < active_cnt);
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      tpw_sel_o <= oslr_pkg::TPW_83C;
    else
      tpw_sel_o <= oslr_pkg::oslr_tpw_sel_t'(thermal_prewarn_threshold_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ipk_sel_o <= oslr_pkg::IPK_2P9A;
    else
    begin
      unique case (inductor_peak_limit_i)
        2'h0, 2'h1: ipk_sel_o <= oslr_pkg::IPK_2P9A;
        2'h2: ipk_sel_o <= oslr_pkg::IPK_3P4A;
        2'h3: ipk_sel_o <= oslr_pkg::IPK_3P9A;
      endcase
    end
  end

  a_mod_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
    (module_count_field_i >= 4'h7) |=> (module_enable_o == 8'hFF))
    else $error("module count does not saturate at eight");
  a_mod_count: assert property (@(posedge clk_i) disable iff (rst_i)
    (module_count_field_i < 4'h7)
      |=> ($countones(module_enable_o) == $past(module_count_field_i) + 1))
    else $error("active module count wrong");
  a_tpw_map: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (tpw_sel_o == oslr_pkg::oslr_tpw_sel_t'($past(thermal_prewarn_threshold_i))))
    else $error("prewarn threshold map wrong");
  a_ipk_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (inductor_peak_limit_i[1] == 1'b0) |=> (ipk_sel_o == oslr_pkg::IPK_2P9A))
    else $error("low peak codes not 2.9 A");
  a_ipk_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (inductor_peak_limit_i == 2'h3) |=> (ipk_sel_o == oslr_pkg::IPK_3P9A))
    else $error("peak code 3 not 3.9 A");
endmodule

// ---- hw/oslr_regs.sv ----
// Purpose: Output stage count and limits configuration registers
// Assumes: Byte write/read strobes from the control interface on clk_i
// Notes: Thermal shutdown event from the same clock domain
`timescale 1ns/1ps
`include "oslr_map.svh"

// Functional notes
// - The upper nibble of the module register selects one to eight active modules, saturating at code seven.
// - With re-arm clear the device stays off after a thermal shutdown.
// - With re-arm set the device restarts its power-up after a thermal shutdown, keeping programmed values.
// - Loading default register values sets the reset indicator flag to one.
// - Writing one to force reset reloads defaults and the bit clears itself, reading zero.
// - The two-bit prewarn field selects 83, 94, 105 or 116 degrees.
// - The two-bit peak field selects 2.9 A for codes 0 and 1, 3.4 A for 2 and 3.9 A for 3.
module oslr_regs (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Thermal
  input wire logic thermal_shutdown_event_i,
  // Converter control
  output logic converter_en_o,
  output logic pwrup_start_o,
  output logic [7:0] module_enable_o,
  output oslr_pkg::oslr_tpw_sel_t tpw_sel_o,
  output oslr_pkg::oslr_ipk_sel_t ipk_sel_o
);
  // ==========================================
  // Register storage
  logic [3:0] module_count_field_reg;
  logic thermal_enable_a_reg;
  logic reset_indicator_flag_reg;
  logic [1:0] thermal_prewarn_threshold_reg;
  logic [1:0] inductor_peak_limit_reg;
  logic force_register_reset;
  logic wr_mod;
  logic wr_lim;
  oslr_pkg::oslr_ts_state_t ts_reg;
  oslr_pkg::oslr_ts_state_t ts_next;
  logic [7:0] pwr_cnt_reg;

  assign wr_mod = wr_en_i && (addr_i == `OSLR_ADDR_MODULE);
  assign wr_lim = wr_en_i && (addr_i == `OSLR_ADDR_LIMCFG);
  // Force bit is never stored, so it reads zero
  assign force_register_reset = wr_lim && wdata_i[`OSLR_FORCE_BIT];

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      module_count_field_reg <= `OSLR_MOD_RST;
    else if (force_register_reset)
      module_count_field_reg <= `OSLR_MOD_RST;
    else if (wr_mod)
      module_count_field_reg <= wdata_i[`OSLR_MOD_MSB:`OSLR_MOD_LSB];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      thermal_enable_a_reg <= `OSLR_THERMAL_ENABLE_A_RST;
      thermal_prewarn_threshold_reg <= `OSLR_TPW_RST;
      inductor_peak_limit_reg <= `OSLR_IPK_RST;
    end
    else if (force_register_reset)
    begin
      thermal_enable_a_reg <= `OSLR_THERMAL_ENABLE_A_RST;
      thermal_prewarn_threshold_reg <= `OSLR_TPW_RST;
      inductor_peak_limit_reg <= `OSLR_IPK_RST;
    end
    else if (wr_lim)
    begin
      thermal_enable_a_reg <= wdata_i[`OSLR_THERMAL_ENABLE_A_BIT];
      thermal_prewarn_threshold_reg <= wdata_i[`OSLR_TPW_MSB:`OSLR_TPW_LSB];
      inductor_peak_limit_reg <= wdata_i[`OSLR_IPK_MSB:`OSLR_IPK_LSB];
    end
  end

  // Default load sets the flag; it wins over a host clear
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      reset_indicator_flag_reg <= 1'b1;
    else if (force_register_reset)
      reset_indicator_flag_reg <= 1'b1;
    else if (wr_lim)
      reset_indicator_flag_reg <= wdata_i[`OSLR_RSTFLAG_BIT];
  end

  // ==========================================
  // Read path
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_en_i)
    begin
      unique case (addr_i)
        `OSLR_ADDR_MODULE: rdata_o <= {module_count_field_reg, 4'h0};
        `OSLR_ADDR_LIMCFG: rdata_o <= {inductor_peak_limit_reg, thermal_prewarn_threshold_reg,
          1'b0, 1'b0, reset_indicator_flag_reg, thermal_enable_a_reg};
        default: rdata_o <= 8'h00;
      endcase
    end
  end

  // ==========================================
  // Thermal shutdown handling
  always_comb
  begin
    ts_next = ts_reg;
    unique case (ts_reg)
      oslr_pkg::TS_RUN:
        if (thermal_shutdown_event_i)
          ts_next = oslr_pkg::TS_OFF;
      oslr_pkg::TS_OFF:
        if (!thermal_shutdown_event_i && thermal_enable_a_reg)
          ts_next = oslr_pkg::TS_PWRUP;
      oslr_pkg::TS_PWRUP:
        if (thermal_shutdown_event_i)
          ts_next = oslr_pkg::TS_OFF;
        else if (pwr_cnt_reg == `OSLR_PWRUP_CYCLES)
          ts_next = oslr_pkg::TS_RUN;
      default: ts_next = oslr_pkg::TS_OFF;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      ts_reg <= oslr_pkg::TS_RUN;
    else
      ts_reg <= ts_next;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      pwr_cnt_reg <= 8'h00;
    else if (ts_reg == oslr_pkg::TS_PWRUP)
      pwr_cnt_reg <= pwr_cnt_reg + 8'h01;
    else
      pwr_cnt_reg <= 8'h00;
  end

  assign converter_en_o = (ts_reg == oslr_pkg::TS_RUN);
  assign pwrup_start_o = (ts_reg == oslr_pkg::TS_OFF) && (ts_next == oslr_pkg::TS_PWRUP);

  oslr_decode u_oslr_decode (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .module_count_field_i(module_count_field_reg),
    .thermal_prewarn_threshold_i(thermal_prewarn_threshold_reg),
    .inductor_peak_limit_i(inductor_peak_limit_reg),
    .module_enable_o(module_enable_o),
    .tpw_sel_o(tpw_sel_o),
    .ipk_sel_o(ipk_sel_o)
  );

  // ==========================================
  // Checks
  a_stay_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (ts_reg == oslr_pkg::TS_OFF && !thermal_enable_a_reg) |=> (ts_reg == oslr_pkg::TS_OFF))
    else $error("restarted without thermal_enable_a");
  a_thermal_enable_a_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (ts_reg == oslr_pkg::TS_OFF && thermal_enable_a_reg && !thermal_shutdown_event_i)
      |=> (ts_reg == oslr_pkg::TS_PWRUP))
    else $error("thermal_enable_a did not restart");
  a_thermal_enable_a_keeps: assert property (@(posedge clk_i) disable iff (rst_i)
    (pwrup_start_o && !wr_en_i) |=> $stable(module_count_field_reg))
    else $error("registers lost on restart");
  a_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    force_register_reset |=> reset_indicator_flag_reg)
    else $error("flag not set on default load");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lim && !wdata_i[1] && !wdata_i[2]) |=> !reset_indicator_flag_reg)
    else $error("flag not cleared by host");
  a_force_defaults: assert property (@(posedge clk_i) disable iff (rst_i)
    force_register_reset
      |=> (module_count_field_reg == 4'h7 && inductor_peak_limit_reg == 2'h3))
    else $error("force reset did not load defaults");
  a_force_reads0: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_en_i && addr_i == 8'h16) |=> (rdata_o[2] == 1'b0))
    else $error("force bit read back as one");
  a_spare_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_en_i && addr_i == 8'h15) |=> (rdata_o[3:0] == 4'h0))
    else $error("spare bits not zero");
  a_spare_limits: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_en_i && addr_i == `OSLR_ADDR_LIMCFG) |=> (rdata_o[3] == 1'b0))
    else $error("limits spare bit not zero");
  a_unmapped_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_en_i && addr_i != `OSLR_ADDR_MODULE && addr_i != `OSLR_ADDR_LIMCFG)
      |=> (rdata_o == 8'h00))
    else $error("unmapped read not zero");

  // ==========================================
  // Thermal sequence checks
  sequence s_trip;
    converter_en_o && thermal_shutdown_event_i;
  endsequence

  sequence s_restart_begin;
    (ts_reg == oslr_pkg::TS_OFF) && thermal_enable_a_reg && !thermal_shutdown_event_i;
  endsequence

  sequence s_pwrup_hold;
    (ts_reg == oslr_pkg::TS_PWRUP) && !converter_en_o;
  endsequence

  a_trip_off: assert property (@(posedge clk_i) disable iff (rst_i)
    s_trip |=> !converter_en_o)
    else $error("converter kept running after shutdown");
  a_restart_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_restart_begin |-> pwrup_start_o)
    else $error("restart pulse missing");
  a_pwrup_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_restart_begin ##1 (!thermal_shutdown_event_i) [*8]) |=> s_pwrup_hold)
    else $error("power-up sequence cut short");
  a_pwrup_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (ts_reg == oslr_pkg::TS_PWRUP && pwr_cnt_reg == `OSLR_PWRUP_CYCLES
      && !thermal_shutdown_event_i) |=> converter_en_o)
    else $error("converter not running after power-up");
endmodule

// ---- testbench/oslr_host.sv ----
// Purpose: Host model that issues register byte reads and writes
// Assumes: Strobes and address change 1 ns after the rising edge
// Notes: Between transfers address and data show the inverse of their last value
`timescale 1ns/1ps

module oslr_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // ==========
  // Byte transfers
  initial
  begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // Strobe stays up across calls so transfers can run back to back
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    wr_en_o = wr;
    rd_en_o = !wr;
    addr_o = a;
    wdata_o = d;
  endtask

  // Drops both strobes; address and data show the inverse while idle
  task automatic idle;
    @(posedge clk_i);
    #1;
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = ~addr_o;
    wdata_o = ~wdata_o;
  endtask
endmodule

// ---- testbench/output_stage_limits_regs_tb_top.sv ----
// Purpose: Self-checking bench for the limits register bank
// Assumes: Read data compared on the falling edge after each read strobe
// Notes: Expected read bytes wait in a queue
`timescale 1ns/1ps

module output_stage_limits_regs_tb_top;
  // ==========
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic thermal_shutdown_event_i = 1'b0;
  logic wr_en;
  logic rd_en;
  logic rd_d = 1'b0;
  logic conv_en;
  logic pwrup;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] mod_en;
  oslr_pkg::oslr_tpw_sel_t tpw;
  oslr_pkg::oslr_ipk_sel_t ipk;
  logic [7:0] exq[$];
  int fail_count = 0;
  int checks = 0;
  integer seed = 32'hA6F6;
  int n;

  always #5 clk_i = ~clk_i;

  oslr_host u_oslr_host (.clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
    .wdata_o(wdata));

  oslr_regs u_oslr_regs (.clk_i(clk_i), .rst_i(rst_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .thermal_shutdown_event_i(thermal_shutdown_event_i), .converter_en_o(conv_en),
    .pwrup_start_o(pwrup), .module_enable_o(mod_en), .tpw_sel_o(tpw), .ipk_sel_o(ipk));

  // ==========
  // Tasks
  task automatic end_sim;
    if (fail_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value read t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("wrong value output t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_oslr_host.xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    exq.push_back(exp);
    u_oslr_host.xfer(1'b0, a, 8'h00);
  endtask

  task automatic settle;
    u_oslr_host.idle();
    repeat (3) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_hi(input bit en_sel, output int cnt);
    cnt = 0;
    while ((en_sel ? conv_en : pwrup) !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      cnt++;
      if (cnt > 50)
      begin
        fail_count++;
        end_sim();
      end
    end
  endtask

  // ==========
  // Read monitor
  always @(posedge clk_i) rd_d <= rd_en;

  always @(negedge clk_i)
    if (rd_d === 1'b1)
      chk_rd(rdata, (exq.size() > 0) ? exq.pop_front() : 8'hXX);

  // ==========
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk_out(mod_en, 8'hFF);
    chk_out({6'h00, ipk}, 8'h02);
    chk_out({7'h00, conv_en}, 8'h01);
    rd(8'h16, 8'hC2);
    rd(8'h15, 8'h70);
    rd(8'h17, 8'h00);
    settle();
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h15, {c[3:0], 4'($random(seed))});
      rd(8'h15, {c[3:0], 4'h0});
      settle();
      n = (c > 7) ? 8 : c + 1;
      chk_out(mod_en, 8'((9'h001 << n) - 9'h001));
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h16, {i[1:0], i[1:0], 1'($random(seed)), 3'h0});
      rd(8'h16, {i[1:0], i[1:0], 4'h0});
      settle();
      chk_out({6'h00, tpw}, 8'(i));
      chk_out({6'h00, ipk}, (i == 0) ? 8'h00 : 8'(i - 1));
    end
    wr(8'h15, 8'h20);
    wr(8'h16, 8'h34);
    rd(8'h16, 8'hC2);
    rd(8'h15, 8'h70);
    settle();
    chk_out(mod_en, 8'hFF);
    wr(8'h16, 8'h00);
    wr(8'h15, 8'h20);
    settle();
    thermal_shutdown_event_i = 1'b1;
    @(posedge clk_i);
    #1;
    thermal_shutdown_event_i = 1'b0;
    chk_out({7'h00, conv_en}, 8'h00);
    repeat (30) @(posedge clk_i);
    #1;
    chk_out({7'h00, conv_en}, 8'h00);
    wr(8'h16, 8'h01);
    u_oslr_host.idle();
    wait_hi(1'b0, n);
    wait_hi(1'b1, n);
    chk_out(8'(n), 8'h12);
    chk_out({7'h00, pwrup}, 8'h00);
    wr(8'h17, 8'($random(seed)));
    rd(8'h15, 8'h20);
    rd(8'h16, 8'h01);
    rd(8'h17, 8'h00);
    settle();
    // Mid-run reset reloads defaults and raises the flag
    rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rd(8'h16, 8'hC2);
    rd(8'h15, 8'h70);
    settle();
    chk_out(mod_en, 8'hFF);
    end_sim();
  end
endmodule
